// ===== design/pionf_top.sv
// Port latches, direction registers, open-drain lines and NMI filter
`timescale 1ns/1ps
`default_nettype none
// How it works
// - input bit reads synchronised pin; writes only touch the latch.
// - output bit reads latch; latch drives the pin.
// - bus-line latch writes ignored in expansion or microprocessor mode.
// - open-drain lines release when latch is one.
// - subclock lines may read undefined with oscillator on as inputs; here they read the synchronised pin as is.
// - each direction bit selects input or output per line.
// - bus-line direction writes ignored in expansion or microprocessor mode.
// - NMI enable, once set, cannot be cleared by writes.
// - shared peripheral inputs all see the same line.
// - peripheral input sees what a peripheral output drives.
// - filter samples line on ticks chosen by three-bit select.
// - filter forwards level after three equal samples.
// - port read of the shared line bypasses the filter.
// - boot-mode pull-up on after reset, up to two slow cycles.
// - mode field: 00 single chip, 01 expansion, 11 microprocessor.
module pionf_top
  import pionf_pkg::*;
#(
  parameter int            NP = PIONF_NPORTS
)(
  input  wire logic              sys_clk,
  input  wire logic              sys_rst,
  input  wire logic [4:0]        reg_addr,
  input  wire logic [7:0]        reg_wdata,
  input  wire logic              reg_wr,
  input  wire logic              reg_rd,
  output logic [7:0]             reg_rdata,
  input  wire logic [NP*8-1:0]   pin_in,
  output logic [NP*8-1:0]        pin_out,
  output logic [NP*8-1:0]        pin_oe_n,
  input  wire logic [NP*8-1:0]   bus_line_mask,
  input  wire logic [NP*8-1:0]   periph_out_en,
  input  wire logic [NP*8-1:0]   periph_out_val,
  output logic [NP*8-1:0]        periph_in,
  input  wire logic              nmi_pin,
  output logic                   nmi_filtered,
  output logic                   boot_pullup_en,
  input  wire logic              slow_osc_tick
);

  ////////////////////////////////////////////////////////////////////////
  logic [7:0]        latch_q [NP];
  logic [7:0]        dir_q   [NP];
  logic [NP*8-1:0]   sync1_q;
  logic [NP*8-1:0]   sync2_q;
  logic              nmi_s1_q;
  logic              nmi_s2_q;
  logic [2:0]        filt_sel_q;
  logic [1:0]        mode_q;
  logic              nmi_en_q;
  logic [7:0]        protect_q;
  logic [2:0]        misc_q;
  logic              unlock_live_q;
  logic [7:0]        rdata_q;
  logic [NP*8-1:0]   out_q;
  logic [NP*8-1:0]   oe_n_q;
  logic [NP*8-1:0]   pin_seen;
  logic              nmi_filt;
  logic              nmi_filt_q;
  logic [1:0]        pull_cnt_q;
  logic              pull_q;

  wire  logic        ext_mode;
  wire  logic        wr_hit_port;
  wire  logic [3:0]  port_idx;
  wire  logic        port_is_dir;
  wire  logic [7:0]  lock_mask;
  wire  logic [7:0]  port_rd_val;
  wire  logic [7:0]  ctl_rd_val;
  wire  logic        dir9_ok;

  function automatic logic [7:0] port_read(input logic [7:0] dir,
                                           input logic [7:0] lat,
                                           input logic [7:0] pin);
    port_read = (dir & lat) | (~dir & pin);
  endfunction

  ////////////////////////////////////////////////////////////////////////
  // mode decode
  assign ext_mode    = (mode_q == PIONF_MODE_MEMEXP) ||
                       (mode_q == PIONF_MODE_MICRO);
  assign port_idx    = reg_addr[4:1];
  assign port_is_dir = reg_addr[0];
  assign wr_hit_port = reg_wr && (int'(port_idx) < NP);
  assign lock_mask   = ext_mode ? bus_line_mask[port_idx*8 +: 8] : 8'h00;
  // Port 9 direction only while the unlock bit is still fresh
  assign dir9_ok     = protect_q[PIONF_UNLOCK_BIT] || (port_idx != 4'h9);
  assign port_rd_val = port_read(dir_q[port_idx], latch_q[port_idx],
                                 sync2_q[port_idx*8 +: 8]);
  assign ctl_rd_val  =
    (reg_addr == PIONF_OFF_FILTER)   ? {5'h00, filt_sel_q} :
    (reg_addr == PIONF_OFF_MODE)     ? {6'h00, mode_q} :
    (reg_addr == PIONF_OFF_NMIEN)    ? {7'h00, nmi_en_q} :
    (reg_addr == PIONF_OFF_PROTECT)  ? protect_q :
    (reg_addr == PIONF_OFF_MISC)     ? {5'h00, misc_q} :
    (reg_addr == PIONF_OFF_FILTSTAT) ? {7'h00, nmi_filt_q} : 8'h00;

  ////////////////////////////////////////////////////////////////////////
  // Port registers per port
  genvar gi;
  generate
    for (gi = 0; gi < NP; gi++) begin : g_port
      wire logic        hit;
      wire logic [7:0]  keep;
      wire logic [7:0]  drv;
      wire logic [7:0]  od_mask;
      assign hit  = wr_hit_port && (int'(port_idx) == gi);
      assign keep = lock_mask;
      assign od_mask =
        (gi == PIONF_OD_PORT_A) ? 8'h03 :
        (gi == PIONF_OD_PORT_B) ? (8'h01 << PIONF_OD85_BIT) : 8'h00;
      assign drv = (periph_out_en[gi*8 +: 8] & periph_out_val[gi*8 +: 8]) |
                   (~periph_out_en[gi*8 +: 8] & latch_q[gi]);
      assign pin_seen[gi*8 +: 8] = sync2_q[gi*8 +: 8];

      always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
          latch_q[gi] <= PIONF_LATCH_RST;
          dir_q[gi]   <= PIONF_DIR_RST;
          out_q[gi*8 +: 8]  <= 8'h00;
          oe_n_q[gi*8 +: 8] <= 8'hff;
        end else begin
          if (hit && !port_is_dir) begin
            latch_q[gi] <= (reg_wdata & ~keep) | (latch_q[gi] & keep);
          end
          if (hit && port_is_dir && dir9_ok) begin
            dir_q[gi] <= (reg_wdata & ~keep) | (dir_q[gi] & keep);
          end
          out_q[gi*8 +: 8]  <= drv & ~od_mask;
          oe_n_q[gi*8 +: 8] <= ~((dir_q[gi] | periph_out_en[gi*8 +: 8]) &
                                 ~(od_mask & drv));
        end
      end
    end
  endgenerate

  ////////////////////////////////////////////////////////////////////////
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      sync1_q  <= '0;
      sync2_q  <= '0;
      nmi_s1_q <= 1'b1;
      nmi_s2_q <= 1'b1;
    end else begin
      sync1_q  <= pin_in;
      sync2_q  <= sync1_q;
      nmi_s1_q <= nmi_pin;
      nmi_s2_q <= nmi_s1_q;
    end
  end

  // Control registers
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      filt_sel_q    <= PIONF_FILT_RST;
      mode_q        <= PIONF_MODE_RST;
      nmi_en_q      <= 1'b0;
      protect_q     <= 8'h00;
      misc_q        <= 3'h0;
      unlock_live_q <= 1'b0;
      rdata_q       <= 8'h00;
    end else begin
      // Filter select is plain storage; safe-change order is software's job
      if (reg_wr && reg_addr == PIONF_OFF_FILTER) begin
        filt_sel_q <= reg_wdata[2:0];
      end
      if (reg_wr && reg_addr == PIONF_OFF_MODE) begin
        mode_q <= reg_wdata[1:0];
      end
      if (reg_wr && reg_addr == PIONF_OFF_NMIEN && reg_wdata[0]) begin
        nmi_en_q <= 1'b1;
      end
      if (reg_wr && reg_addr == PIONF_OFF_MISC) begin
        misc_q <= reg_wdata[2:0];
      end
      // Unlock stays armed across idle cycles until the next write
      if (reg_wr && reg_addr == PIONF_OFF_PROTECT) begin
        unlock_live_q <= reg_wdata[PIONF_UNLOCK_BIT];
      end else if (reg_wr) begin
        unlock_live_q <= 1'b0;
      end
      if (reg_wr && reg_addr == PIONF_OFF_PROTECT) begin
        protect_q <= reg_wdata;
      end else if (reg_wr && unlock_live_q) begin
        protect_q[PIONF_UNLOCK_BIT] <= 1'b0;
      end
      // subclock lines read pin as is
      if (reg_rd) begin
        rdata_q <= (int'(port_idx) < NP) ?
                   (port_is_dir ? dir_q[port_idx] : port_rd_val) :
                   ctl_rd_val;
      end else begin
        rdata_q <= 8'h00;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  pionf_filter u_filter (
    .sys_clk   (sys_clk),
    .sys_rst   (sys_rst),
    .sel       (filt_sel_q),
    .level_in  (nmi_s2_q),
    .level_out (nmi_filt)
  );

  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      nmi_filt_q <= 1'b1;
      pull_cnt_q <= 2'h0;
      pull_q     <= 1'b1;
    end else begin
      nmi_filt_q <= nmi_filt;
      if (pull_q && slow_osc_tick) begin
        pull_cnt_q <= pull_cnt_q + 2'h1;
        if (pull_cnt_q == 2'h1) begin
          pull_q <= 1'b0;
        end
      end
    end
  end

  // port read path uses raw sync, not filter
  assign periph_in      = pin_seen;
  assign reg_rdata      = rdata_q;
  assign pin_out        = out_q;
  assign pin_oe_n       = oe_n_q;
  assign nmi_filtered   = nmi_filt_q;
  assign boot_pullup_en = pull_q;

endmodule
`default_nettype wire

// ===== pkg/pionf_pkg.sv
// Package: constants and types of the port block with the interrupt filter
package pionf_pkg;

  localparam int          PIONF_NPORTS       = 11;
  localparam int          PIONF_AW           = 5;
  // Register map: index i*2 = latch, i*2+1 = direction, then control regs
  localparam logic [4:0]  PIONF_OFF_LATCH0   = 5'h00;
  localparam logic [4:0]  PIONF_OFF_DIR0     = 5'h01;
  localparam logic [4:0]  PIONF_OFF_FILTER   = 5'h16;
  localparam logic [4:0]  PIONF_OFF_MODE     = 5'h17;
  localparam logic [4:0]  PIONF_OFF_NMIEN    = 5'h18;
  localparam logic [4:0]  PIONF_OFF_PROTECT  = 5'h19;
  localparam logic [4:0]  PIONF_OFF_MISC     = 5'h1a;
  localparam logic [4:0]  PIONF_OFF_FILTSTAT = 5'h1b;
  // Field positions
  localparam int          PIONF_UNLOCK_BIT   = 2;
  localparam int          PIONF_SUBOSC_BIT   = 0;
  localparam int          PIONF_THREE_PHASE_TIMER_ENABLE_BIT    = 1;
  localparam int          PIONF_THREE_PHASE_OUTPUT_ENABLE_BIT    = 2;
  // Reset values
  localparam logic [7:0]  PIONF_LATCH_RST    = 8'h00;
  localparam logic [7:0]  PIONF_DIR_RST      = 8'h00;
  localparam logic [2:0]  PIONF_FILT_RST     = 3'h0;
  localparam logic [1:0]  PIONF_MODE_RST     = 2'h0;
  // Processor modes
  localparam logic [1:0]  PIONF_MODE_SINGLE  = 2'b00;
  localparam logic [1:0]  PIONF_MODE_MEMEXP  = 2'b01;
  localparam logic [1:0]  PIONF_MODE_MICRO   = 2'b11;
  // Open-drain and subclock line positions (port, bit)
  localparam int          PIONF_OD_PORT_A    = 7;
  localparam int          PIONF_OD_PORT_B    = 8;
  localparam int          PIONF_OD85_BIT     = 5;
  localparam int          PIONF_SUBA_BIT     = 6;
  localparam int          PIONF_SUBB_BIT     = 7;
  // Filter needs this many equal samples
  localparam int          PIONF_FILT_SAMPLES = 3;
  localparam int          PIONF_DIV_W        = 8;

  typedef struct packed {
    logic                 wr;
    logic                 rd;
    logic [4:0]           addr;
    logic [7:0]           wdata;
  } pionf_req_t;

endpackage

// ===== design/pionf_filter.sv
// Three-sample digital filter with selectable sampling tick
`timescale 1ns/1ps
`default_nettype none
module pionf_filter
  import pionf_pkg::*;
(
  input  wire logic        sys_clk,
  input  wire logic        sys_rst,
  input  wire logic [2:0]  sel,
  input  wire logic        level_in,
  output logic             level_out
);

  logic [PIONF_DIV_W-1:0]  div_q;
  logic [2:0]              hist_q;
  logic                    out_q;
  wire  logic              tick;
  wire  logic              all_hi;
  wire  logic              all_lo;

  // Tick every 2**sel cycles
  assign tick   = (div_q & ((8'h01 << sel) - 8'h01)) == 8'h00;
  assign all_hi = &hist_q;
  assign all_lo = ~|hist_q;
  assign level_out = out_q;

  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      div_q  <= 8'h00;
      hist_q <= 3'h7;
      out_q  <= 1'b1;
    end else begin
      div_q <= div_q + 8'h01;
      if (tick) begin
        hist_q <= {hist_q[1:0], level_in};
      end
      if (all_hi) begin
        out_q <= 1'b1;
      end else if (all_lo) begin
        out_q <= 1'b0;
      end
    end
  end

endmodule
`default_nettype wire

// ===== testbench/pionf_properties.sv
// Checker: port drive, sync, filter and boot pull-up properties
`timescale 1ns/1ps
`default_nettype none
module pionf_properties
  import pionf_pkg::*;
#(
  parameter int NP = PIONF_NPORTS
)(
  input wire logic            sys_clk,
  input wire logic            sys_rst,
  input wire logic [4:0]      reg_addr,
  input wire logic            reg_rd,
  input wire logic [7:0]      reg_rdata,
  input wire logic [NP*8-1:0] pin_in,
  input wire logic [NP*8-1:0] pin_out,
  input wire logic [NP*8-1:0] pin_oe_n,
  input wire logic [NP*8-1:0] periph_out_en,
  input wire logic [NP*8-1:0] periph_out_val,
  input wire logic [NP*8-1:0] periph_in,
  input wire logic            nmi_pin,
  input wire logic            nmi_filtered,
  input wire logic            boot_pullup_en,
  input wire logic            slow_osc_tick
);
  localparam logic [NP*8-1:0] ONE = (NP*8)'(1);
  localparam logic [NP*8-1:0] OD_M = (ONE << 56) | (ONE << 57) | (ONE << 69);
  logic [1:0] live_q;
  logic [9:0] calm_q;
  logic       nmi_q;
  // Calm count lets filter checks skip the sync pipeline
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      live_q <= 2'h0;
      calm_q <= 10'h000;
    end else begin
      live_q <= (live_q == 2'h3) ? live_q : live_q + 2'h1;
      calm_q <= (nmi_pin != nmi_q) ? 10'h000 :
                (calm_q == 10'h3ff) ? calm_q : calm_q + 10'h001;
    end
    nmi_q <= nmi_pin;
  end
  //////////////////////////////
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (sys_rst);
  sequence s_rd_done;
    $past(reg_rd) ##0 live_q == 2'h3;
  endsequence
  property p_rd_idle;
    live_q == 2'h3 && !$past(reg_rd) |-> reg_rdata == 8'h00;
  endproperty
  property p_unmapped;
    s_rd_done ##0 $past(reg_addr) > PIONF_OFF_FILTSTAT |-> reg_rdata == 8'h00;
  endproperty
  property p_od_release;
    (~pin_oe_n & pin_out & OD_M) == '0;
  endproperty
  property p_rst_vals;
    $fell(sys_rst) |-> &pin_oe_n && boot_pullup_en && nmi_filtered;
  endproperty
  property p_boot_fall;
    $fell(boot_pullup_en) |-> $past(slow_osc_tick) || $past(slow_osc_tick, 2);
  endproperty
  property p_sync;
    live_q == 2'h3 |-> periph_in == $past(pin_in, 2);
  endproperty
  property p_periph_drv;
    live_q == 2'h3 |-> ($past(periph_out_en) & ~OD_M
      & (pin_oe_n | (pin_out ^ $past(periph_out_val)))) == '0;
  endproperty
  property p_filt_hold;
    calm_q >= 10'd8 && nmi_pin == nmi_filtered |=> $stable(nmi_filtered);
  endproperty
  property p_filt_follow;
    calm_q >= 10'd600 |-> nmi_filtered == nmi_pin;
  endproperty
  a_rd_idle: assert property (p_rd_idle) else $error("rdata not idle");
  a_unmapped: assert property (p_unmapped) else $error("unmapped read");
  a_od_release: assert property (p_od_release) else $error("od high");
  a_rst_vals: assert property (p_rst_vals) else $error("reset state");
  a_boot_fall: assert property (p_boot_fall) else $error("pullup");
  a_sync: assert property (p_sync) else $error("sync path");
  a_periph_drv: assert property (p_periph_drv) else $error("drive");
  a_filt_hold: assert property (p_filt_hold) else $error("filt");
  a_filt_follow: assert property (p_filt_follow) else $error("lag");
endmodule
bind pionf_top pionf_properties #(.NP(NP)) pionf_properties_i (
  .sys_clk, .sys_rst, .reg_addr, .reg_rd, .reg_rdata, .pin_in, .pin_out,
  .pin_oe_n, .periph_out_en, .periph_out_val, .periph_in, .nmi_pin,
  .nmi_filtered, .boot_pullup_en, .slow_osc_tick);
`default_nettype wire

// ===== testbench/pionf_pins.sv
// Partner: external line levels seen by the port block
`timescale 1ns/1ps
`default_nettype none
module pionf_pins #(
  parameter int W = 88
)(
  input  wire logic         sys_clk,
  input  wire logic [W-1:0] pin_out,
  input  wire logic [W-1:0] pin_oe_n,
  input  wire logic [W-1:0] ext_en,
  input  wire logic [W-1:0] ext_val,
  output logic [W-1:0]      pin_in
);
  logic [W-1:0] float_q = '0;
  // Undriven lines wander so a stale level never passes
  always @(posedge sys_clk) float_q <= ~float_q;
  assign pin_in = (~pin_oe_n & pin_out) | (pin_oe_n & ext_en & ext_val)
                | (pin_oe_n & ~ext_en & float_q);
endmodule
`default_nettype wire

// ===== testbench/pionf_top_tb.sv
// Testbench: registers, lines, locks, filter and boot pull-up
`timescale 1ns/1ps
`default_nettype none
module pionf_top_tb
  import pionf_pkg::*;
;
  localparam int W = PIONF_NPORTS * 8;
  logic sys_clk, sys_rst, reg_wr, reg_rd, nmi_pin, slow_osc_tick;
  logic nmi_filtered, boot_pullup_en;
  logic [4:0] reg_addr;
  logic [7:0] reg_wdata, reg_rdata, v, old, d;
  logic [W-1:0] pin_in, pin_out, pin_oe_n, bus_line_mask, periph_out_en;
  logic [W-1:0] periph_out_val, periph_in, ext_en, ext_val;
  logic [31:0] rnd;
  logic [1:0] modes [3] = '{PIONF_MODE_SINGLE, PIONF_MODE_MEMEXP,
                            PIONF_MODE_MICRO};
  int fail_count, checked, n;
  pionf_top #(.NP(PIONF_NPORTS)) pionf_top_i (.sys_clk, .sys_rst, .reg_addr,
    .reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .pin_in, .pin_out, .pin_oe_n,
    .bus_line_mask, .periph_out_en, .periph_out_val, .periph_in, .nmi_pin,
    .nmi_filtered, .boot_pullup_en, .slow_osc_tick);
  pionf_pins #(.W(W)) pionf_pins_i (.sys_clk, .pin_out, .pin_oe_n, .ext_en,
    .ext_val, .pin_in);
  //////////////////////////////
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  // Bus lines keep old bits outside single-chip mode
  function automatic logic [7:0] lock(input logic [1:0] m,
                                      input logic [7:0] o, w, k);
    return (m == PIONF_MODE_SINGLE) ? w : (o & k) | (w & ~k);
  endfunction
  task automatic check(input string nm, input logic [7:0] s, e);
    checked++;
    if (s !== e) begin
      fail_count++;
      $display("wrong value %s expected %h seen %h", nm, e, s);
    end
  endtask
  task automatic tick(input int c);
    repeat (c) @(posedge sys_clk);
    #1;
  endtask
  task automatic wr(input logic [4:0] a, input logic [7:0] w);
    @(posedge sys_clk);
    {reg_wr, reg_addr, reg_wdata} <= {1'b1, a, w};
    @(posedge sys_clk);
    reg_wr <= 1'b0;
  endtask
  task automatic rd(input logic [4:0] a, input logic [7:0] e);
    @(posedge sys_clk);
    {reg_rd, reg_addr} <= {1'b1, a};
    @(posedge sys_clk);
    reg_rd <= 1'b0;
    #1;
    check("rdata", reg_rdata, e);
  endtask
  task automatic print_verdict;
    $display("checks %0d mismatches %0d", checked, fail_count);
    if (fail_count == 0 && checked > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  initial begin
    sys_clk = 1'b0;
    forever #20 sys_clk = ~sys_clk;
  end
  initial begin
    repeat (20000) @(posedge sys_clk);
    fail_count++;
    print_verdict;
  end
  initial begin
    {reg_wr, reg_rd, nmi_pin, slow_osc_tick, reg_addr, reg_wdata} = 17'h4000;
    {bus_line_mask, periph_out_en, periph_out_val, ext_en, ext_val} = '0;
    sys_rst = 1'b1;
    rnd = 32'h0726;
    repeat (4) @(posedge sys_clk);
    sys_rst <= 1'b0;
    tick(1);
    check("boot", 8'(boot_pullup_en), 8'h01);
    repeat (2) begin
      @(posedge sys_clk);
      slow_osc_tick <= 1'b1;
      @(posedge sys_clk);
      slow_osc_tick <= 1'b0;
    end
    tick(3);
    check("boot", 8'(boot_pullup_en), 8'h00);
    for (int k = 0; k < 6; k++) begin
      rnd = lfsr(rnd);
      d = (k == 0) ? 8'h00 : (k == 1) ? 8'hff : rnd[7:0];
      wr(PIONF_OFF_DIR0, d);
      wr(PIONF_OFF_LATCH0, rnd[15:8]);
      ext_en[7:0] <= ~d;
      ext_val[7:0] <= rnd[23:16];
      tick(4);
      check("oe", pin_oe_n[7:0], ~d);
      check("out", pin_out[7:0] & d, rnd[15:8] & d);
      rd(PIONF_OFF_LATCH0, (rnd[15:8] & d) | (rnd[23:16] & ~d));
    end
    wr(5'h0f, 8'hff);
    wr(5'h11, 8'hff);
    for (int i = 0; i < 2; i++) begin
      wr(5'h0e, i ? 8'h00 : 8'hff);
      wr(5'h10, i ? 8'h00 : 8'hff);
      tick(2);
      check("od7", pin_oe_n[63:56], i ? 8'h00 : 8'h03);
      check("od8", pin_oe_n[71:64], i ? 8'h00 : 8'h20);
    end
    // peripheral input on a direction-0 line
    rnd = lfsr(rnd);
    periph_out_en[23:16] <= 8'hff;
    periph_out_val[23:16] <= rnd[7:0];
    tick(4);
    check("pin", periph_in[23:16], rnd[7:0]);
    rd(5'h04, rnd[7:0]);
    periph_out_en[23:16] <= 8'h00;
    bus_line_mask[15:8] <= 8'h0f;
    ext_en[15:8] <= 8'hff;
    ext_val[15:8] <= 8'ha5;
    {old, d} = 16'h00ff;
    wr(5'h03, d);
    foreach (modes[i]) begin
      rnd = lfsr(rnd);
      wr(PIONF_OFF_MODE, 8'(modes[i]));
      rd(PIONF_OFF_MODE, 8'(modes[i]));
      wr(5'h02, rnd[7:0]);
      old = lock(modes[i], old, rnd[7:0], 8'h0f);
      rd(5'h02, (old & d) | (8'ha5 & ~d));
      wr(5'h03, rnd[15:8]);
      d = lock(modes[i], d, rnd[15:8], 8'h0f);
      rd(5'h03, d);
    end
    wr(PIONF_OFF_MODE, 8'(PIONF_MODE_SINGLE));
    wr(5'h13, 8'hff);
    rd(5'h13, 8'h00);
    wr(PIONF_OFF_PROTECT, 8'h04);
    wr(5'h13, 8'h3c);
    rd(5'h13, 8'h3c);
    wr(5'h13, 8'h55);
    rd(5'h13, 8'h3c);
    wr(PIONF_OFF_MISC, 8'h00);
    wr(PIONF_OFF_FILTER, 8'h00);
    @(posedge sys_clk);
    nmi_pin <= 1'b0;
    @(posedge sys_clk);
    nmi_pin <= 1'b1;
    tick(10);
    check("glitch", 8'(nmi_filtered), 8'h01);
    for (int s = 0; s < 4; s++) begin
      wr(PIONF_OFF_FILTER, 8'(s));
      @(posedge sys_clk);
      nmi_pin <= ~nmi_pin;
      tick(1);
      n = 1;
      while (nmi_filtered !== nmi_pin && n < 400) begin
        tick(1);
        n++;
      end
      check("lag", 8'(n >= (2 << s) && n <= (3 << s) + 6), 8'h01);
    end
    wr(PIONF_OFF_NMIEN, 8'h01);
    wr(PIONF_OFF_NMIEN, 8'h00);
    rd(PIONF_OFF_NMIEN, 8'h01);
    rd(5'h1f, 8'h00);
    tick(700);
    print_verdict;
  end
endmodule
`default_nettype wire
